/* design/csf_alu_if.sv */
// csf_alu_if.sv: flag results passed from the flag logic to the register.
// assumes: both ends on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface csf_alu_if;
	logic [7:0] result;
	logic zero;
	logic dcarry;
	logic carry;
	logic z_upd;
	logic dc_upd;
	logic c_upd;
	modport calc (output result, zero, dcarry, carry, z_upd, dc_upd, c_upd);
	modport use_flags (input result, zero, dcarry, carry, z_upd, dc_upd,
		c_upd);
endinterface : csf_alu_if

`default_nettype wire

/* design/csf_flag_calc.sv */
// csf_flag_calc.sv: combinational arithmetic flag logic.
// assumes: operands stable during the execute cycle.
`timescale 1ns/100ps
`default_nettype none
`include "csf_regs.svh"

module csf_flag_calc (
	input wire csf_pkg::csf_flag_op_type flag_op,
	input wire logic [7:0] operand_w,
	input wire logic [7:0] operand_f,
	input wire logic carry_in,
	csf_alu_if.calc flags
);

	logic [8:0] sum;
	logic [4:0] nib;

	function automatic logic [8:0] add9(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
	endfunction : add9

	// ----------------------------------------------------------------
	// flag computation
	// ----------------------------------------------------------------
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		flags.result = operand_f;
		flags.zero = 1'b0;
		flags.dcarry = 1'b0;
		flags.carry = 1'b0;
		flags.z_upd = 1'b0;
		flags.dc_upd = 1'b0;
		flags.c_upd = 1'b0;
		case (flag_op)
		csf_pkg::CSF_FLAGS_Z: begin
			flags.z_upd = 1'b1;
		end
		// [R14] add carries
		csf_pkg::CSF_FLAGS_ADD: begin
			sum = add9(operand_f, operand_w, 1'b0);
			nib = {1'b0, operand_f[3:0]} + {1'b0, operand_w[3:0]};
			flags.result = sum[7:0];
			flags.carry = sum[8];
			flags.dcarry = nib[4];
			{flags.z_upd, flags.dc_upd, flags.c_upd} = 3'h7;
		end
		// [R14] inverted borrows
		csf_pkg::CSF_FLAGS_SUB: begin
			sum = add9(operand_f, ~operand_w, 1'b1);
			nib = {1'b0, operand_f[3:0]} + {1'b0, ~operand_w[3:0]} + 5'h01;
			flags.result = sum[7:0];
			flags.carry = sum[8];
			flags.dcarry = nib[4];
			{flags.z_upd, flags.dc_upd, flags.c_upd} = 3'h7;
		end
		// [R10] lsb into carry
		csf_pkg::CSF_FLAGS_RRF: begin
			flags.result = {carry_in, operand_f[7:1]};
			flags.carry = operand_f[0];
			flags.c_upd = 1'b1;
		end
		// [R10] msb into carry
		csf_pkg::CSF_FLAGS_RLF: begin
			flags.result = {operand_f[6:0], carry_in};
			flags.carry = operand_f[`CSF_BYTE_MSB];
			flags.c_upd = 1'b1;
		end
		default: begin
			flags.result = operand_f;
		end
		endcase
		// [R13] zero on result
		flags.zero = (flags.result == 8'h00);
	end

endmodule : csf_flag_calc

`default_nettype wire

/* design/csf_pkg.sv */
// csf_pkg.sv: types shared by the status flag block.
// assumes: csf_regs.svh on the include path.
`include "csf_regs.svh"

package csf_pkg;

	// ----------------------------------------------------------------
	// flag update kinds
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CSF_FLAGS_NONE = 3'b000,
		CSF_FLAGS_Z = 3'b001,
		CSF_FLAGS_ADD = 3'b010,
		CSF_FLAGS_SUB = 3'b011,
		CSF_FLAGS_RRF = 3'b100,
		CSF_FLAGS_RLF = 3'b101
	} csf_flag_op_type;

	typedef enum logic [1:0] {
		CSF_PWR_NONE = 2'b00,
		CSF_PWR_WDT_CLEAR = 2'b01,
		CSF_PWR_SLEEP = 2'b10,
		CSF_PWR_WDT_TIMEOUT = 2'b11
	} csf_pwr_event_type;

	typedef struct packed {
		logic [2:0] page;
		logic tout;
		logic pdown;
		logic zero;
		logic dcarry;
		logic carry;
	} csf_status_type;

endpackage : csf_pkg

/* design/csf_regs.svh */
// csf_regs.svh: offsets, field positions and reset values of the status flag
// register of the core.
// assumes: included by bare name from package and modules.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// ----------------------------------------------------------------
// address and fields
// ----------------------------------------------------------------
`define CSF_STATUS_ADDR 5'h03
`define CSF_BIT_CARRY 0
`define CSF_BIT_DCARRY 1
`define CSF_BIT_ZERO 2
`define CSF_BIT_PDOWN 3
`define CSF_BIT_TOUT 4
`define CSF_BIT_PAGE_LO 5
`define CSF_BIT_PAGE_HI 6
`define CSF_BIT_PAGE_RSV 7
`define CSF_PAGE_RST 3'h0
`define CSF_TOUT_RST 1'h1
`define CSF_PDOWN_RST 1'h1
`define CSF_ARITH_RST 3'h0
`define CSF_NIBBLE_MSB 3
`define CSF_BYTE_MSB 7

`endif

/* design/csf_status_reg.sv */
// csf_status_reg.sv: status flag register of the 8-bit core.
// assumes: one instruction per enabled clock; master_clear is a pin.
//
// Operation
// [R1] any instruction may write the register's writable bits
// [R2] flag-affecting writes keep hardware zero, digit carry, carry
// [R3] data writes never change timeout or powerdown flags
// [R4] clear op: page bits zero, zero flag set, others kept
// [R5] register holds arithmetic, reset-cause and page preselect bits
// [R6] at address 03h; reset pages 0, timeout and powerdown 1
// [R7] bits 6 to 5 choose one of four program pages
// [R8] timeout set on power-up, watchdog clear, sleep; cleared on timeout
// [R9] powerdown set on power-up, watchdog clear; cleared by sleep
// [R10] rotates load carry with bit shifted out
// [R11] low master_clear resets the register; code resets only page, timeout and powerdown, keeps arithmetic flags
// [R12] call copies page bits into program counter bits 10 to 9
// [R13] zero flag set when eight-bit result is zero
// [R14] add/subtract set digit carry and carry, borrows inverted
`timescale 1ns/100ps
`default_nettype none
`include "csf_regs.svh"

module csf_status_reg (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic master_clear_n,
	input wire logic instr_en,
	input wire logic [4:0] file_addr,
	input wire logic file_we,
	input wire logic [7:0] file_wdata,
	output logic [7:0] file_rdata,
	input wire logic clear_file_op,
	input wire csf_pkg::csf_flag_op_type flag_op,
	input wire logic [7:0] operand_w,
	input wire logic [7:0] operand_f,
	output logic [7:0] alu_result,
	input wire csf_pkg::csf_pwr_event_type pwr_event,
	input wire logic call_op,
	input wire logic [7:0] call_target,
	output logic [10:0] call_pc,
	output logic [1:0] page_select,
	output logic timeout_flag,
	output logic powerdown_flag
);

	typedef struct packed {
		logic master_clear_meta;
		logic master_clear_sync;
		csf_pkg::csf_status_type st;
		logic [7:0] rdata;
		logic [10:0] pc;
	} csf_state_type;

	csf_state_type cur;
	csf_state_type next_cur;
	csf_alu_if alu ();
	logic hit;
	logic [7:0] wr;

	csf_flag_calc u_calc (
		.flag_op(flag_op),
		.operand_w(operand_w),
		.operand_f(operand_f),
		.carry_in(cur.st.carry),
		.flags(alu)
	);

	function automatic logic [7:0] pack_status(
		input csf_pkg::csf_status_type s);
		pack_status = s;
	endfunction : pack_status

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		wr = file_wdata;
		next_cur.master_clear_meta = master_clear_n;
		next_cur.master_clear_sync = cur.master_clear_meta;
		// [R6] decode at 03h
		hit = (file_addr == `CSF_STATUS_ADDR);
		if (!cur.master_clear_sync) begin
			// [R11] master clear reset
			next_cur.st.page = `CSF_PAGE_RST;
			next_cur.st.tout = `CSF_TOUT_RST;
			next_cur.st.pdown = `CSF_PDOWN_RST;
			next_cur.pc = 11'h000;
		end else if (instr_en) begin
			// [R1] file write
			if (hit && file_we) begin
				next_cur.st.page = wr[`CSF_BIT_PAGE_RSV:`CSF_BIT_PAGE_LO];
				next_cur.st.zero = wr[`CSF_BIT_ZERO];
				next_cur.st.dcarry = wr[`CSF_BIT_DCARRY];
				next_cur.st.carry = wr[`CSF_BIT_CARRY];
			end
			// [R4] clear op
			if (hit && clear_file_op) begin
				next_cur.st.page = `CSF_PAGE_RST;
			end
			// [R2] flag logic wins
			if (alu.z_upd) begin
				next_cur.st.zero = alu.zero;
			end
			if (alu.dc_upd) begin
				next_cur.st.dcarry = alu.dcarry;
			end
			if (alu.c_upd) begin
				next_cur.st.carry = alu.carry;
			end
			// [R4] clear sets zero
			if (clear_file_op) begin
				next_cur.st.zero = 1'b1;
			end
			// [R3] only events move tout/pdown
			case (pwr_event)
			// [R8] [R9] watchdog clear
			csf_pkg::CSF_PWR_WDT_CLEAR: begin
				next_cur.st.tout = 1'b1;
				next_cur.st.pdown = 1'b1;
			end
			// [R8] [R9] sleep
			csf_pkg::CSF_PWR_SLEEP: begin
				next_cur.st.tout = 1'b1;
				next_cur.st.pdown = 1'b0;
			end
			// [R8] timeout clears
			csf_pkg::CSF_PWR_WDT_TIMEOUT: begin
				next_cur.st.tout = 1'b0;
			end
			default: begin
				next_cur.st.tout = cur.st.tout;
			end
			endcase
			// [R12] call target
			if (call_op) begin
				next_cur.pc = {cur.st.page[1:0], 1'b0, call_target};
			end
		end
		next_cur.rdata = pack_status(next_cur.st);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			// [R6] power-on values
			cur <= '0;
			cur.master_clear_meta <= 1'b1;
			cur.master_clear_sync <= 1'b1;
			cur.st.tout <= `CSF_TOUT_RST;
			cur.st.pdown <= `CSF_PDOWN_RST;
			cur.rdata <= {`CSF_PAGE_RST, `CSF_TOUT_RST, `CSF_PDOWN_RST,
				`CSF_ARITH_RST};
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign file_rdata = cur.rdata;
	assign alu_result = alu.result;
	assign call_pc = cur.pc;
	// [R5] [R7] page preselect
	assign page_select = cur.st.page[1:0];
	assign timeout_flag = cur.st.tout;
	assign powerdown_flag = cur.st.pdown;

endmodule : csf_status_reg

`default_nettype wire

/* tb/csf_exec_model.sv */
// csf_exec_model.sv: instruction side feeding the status register.
// assumes: inputs change at the falling edge of clk.
`timescale 1ns/100ps
`default_nettype none

module csf_exec_model (
	input wire logic clk,
	output logic master_clear_n,
	output logic instr_en,
	output logic [4:0] file_addr,
	output logic file_we,
	output logic [7:0] file_wdata,
	output logic clear_file_op,
	output csf_pkg::csf_flag_op_type flag_op,
	output logic [7:0] operand_w,
	output logic [7:0] operand_f,
	output csf_pkg::csf_pwr_event_type pwr_event,
	output logic call_op,
	output logic [7:0] call_target
);
	// --------------------------------
	// one instruction per call
	// --------------------------------
	initial begin
		{master_clear_n, instr_en, file_addr, file_we} = 8'h80;
		{file_wdata, clear_file_op, operand_w, operand_f} = '0;
		{call_op, call_target} = '0;
		flag_op = csf_pkg::CSF_FLAGS_NONE;
		pwr_event = csf_pkg::CSF_PWR_NONE;
	end
	task automatic issue(input logic [4:0] a, input logic we,
		input logic [7:0] d, input logic clr,
		input csf_pkg::csf_flag_op_type op, input logic [7:0] w,
		input logic [7:0] f, input csf_pkg::csf_pwr_event_type pe,
		input logic cl);
		@(negedge clk);
		{file_addr, file_we, file_wdata, clear_file_op} = {a, we, d, clr};
		{operand_w, operand_f, call_op, call_target} = {w, f, cl, d};
		flag_op = op;
		pwr_event = pe;
		instr_en = 1'b1;
		@(negedge clk);
		instr_en = 1'b0;
	endtask : issue
	task automatic master_clear(input logic v);
		@(negedge clk);
		master_clear_n = v;
		repeat (5) @(negedge clk);
	endtask : master_clear
endmodule : csf_exec_model

`default_nettype wire

/* tb/csf_status_reg_monitor.sv */
// csf_status_reg_monitor.sv: port assertions for the status register.
// assumes: bound onto csf_status_reg, one clock.
`timescale 1ns/100ps
`default_nettype none

module csf_status_reg_monitor (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic master_clear_n,
	input wire logic instr_en,
	input wire logic [4:0] file_addr,
	input wire logic file_we,
	input wire logic [7:0] file_wdata,
	input wire logic [7:0] file_rdata,
	input wire logic clear_file_op,
	input wire csf_pkg::csf_flag_op_type flag_op,
	input wire logic [7:0] alu_result,
	input wire csf_pkg::csf_pwr_event_type pwr_event,
	input wire logic [1:0] page_select,
	input wire logic timeout_flag,
	input wire logic powerdown_flag
);
	// --------------------------------
	// checks
	// --------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire logic st = instr_en && file_addr == 5'h03;
	wire logic pn = pwr_event == csf_pkg::CSF_PWR_NONE;
	sequence s_mc_held;
		!master_clear_n [*4];
	endsequence
	a_reset_value: assert property ($rose(arst_n) |->
		file_rdata == 8'h18) else $error("reset value");
	a_sleep_flags: assert property (instr_en &&
		pwr_event == csf_pkg::CSF_PWR_SLEEP |=> timeout_flag &&
		!powerdown_flag) else $error("sleep flags");
	a_wdt_timeout: assert property (instr_en &&
		pwr_event == csf_pkg::CSF_PWR_WDT_TIMEOUT |=> !timeout_flag &&
		$stable(powerdown_flag)) else $error("timeout flags");
	a_page_write: assert property (st && file_we && !clear_file_op
		|=> file_rdata[7:5] == $past(file_wdata[7:5])) else $error("page");
	a_clear_page: assert property (st && clear_file_op && pn |=>
		file_rdata[7:5] == 3'h0 && file_rdata[2] &&
		$stable(file_rdata[4:3])) else $error("clear op");
	a_zero_result: assert property (instr_en && !clear_file_op &&
		flag_op inside {csf_pkg::CSF_FLAGS_ADD, csf_pkg::CSF_FLAGS_SUB}
		|=> file_rdata[2] == ($past(alu_result) == 8'h00))
		else $error("zero flag");
	a_data_nowrite: assert property (st && file_we && pn |=>
		$stable({timeout_flag, powerdown_flag})) else $error("ro bits");
	a_master_clear_reset: assert property (s_mc_held |-> timeout_flag &&
		powerdown_flag && page_select == 2'h0) else $error("master_clear");
endmodule : csf_status_reg_monitor

bind csf_status_reg csf_status_reg_monitor csf_status_reg_monitor_i (
	.clk, .arst_n, .master_clear_n, .instr_en, .file_addr, .file_we,
	.file_wdata, .file_rdata, .clear_file_op, .flag_op, .alu_result,
	.pwr_event, .page_select, .timeout_flag, .powerdown_flag);

`default_nettype wire

/* tb/csf_status_reg_tb_top.sv */
// csf_status_reg_tb_top.sv: directed tests of the status register.
// assumes: design, model and monitor compiled before it.
`timescale 1ns/100ps
`default_nettype none

module csf_status_reg_tb_top;
	// --------------------------------
	// wiring and helpers
	// --------------------------------
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic master_clear_n, instr_en, file_we, clear_file_op, call_op;
	logic [4:0] file_addr;
	logic [7:0] file_wdata, file_rdata, operand_w, operand_f, alu_result;
	logic [7:0] call_target;
	logic [10:0] call_pc;
	logic [1:0] page_select;
	logic timeout_flag, powerdown_flag;
	csf_pkg::csf_flag_op_type flag_op;
	csf_pkg::csf_pwr_event_type pwr_event;
	int mismatches = 0;
	int num_checks = 0;
	csf_status_reg csf_status_reg_i (.clk, .arst_n, .master_clear_n,
		.instr_en, .file_addr, .file_we, .file_wdata, .file_rdata,
		.clear_file_op, .flag_op, .operand_w, .operand_f, .alu_result,
		.pwr_event, .call_op, .call_target, .call_pc, .page_select,
		.timeout_flag, .powerdown_flag);
	csf_exec_model csf_exec_model_i (.clk, .master_clear_n, .instr_en,
		.file_addr, .file_we, .file_wdata, .clear_file_op, .flag_op,
		.operand_w, .operand_f, .pwr_event, .call_op, .call_target);
	always #4 clk = ~clk;
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		csf_exec_model_i.issue(a, 1, d, 0, csf_pkg::CSF_FLAGS_NONE, 0, 0,
			csf_pkg::CSF_PWR_NONE, 0);
	endtask : wr
	task automatic alu(input csf_pkg::csf_flag_op_type op,
		input logic [7:0] w, input logic [7:0] f, input logic [2:0] exp);
		csf_exec_model_i.issue(5'h03, 1, 8'h00, 0, op, w, f,
			csf_pkg::CSF_PWR_NONE, 0);
		check(11'(file_rdata[2:0]), 11'(exp));
	endtask : alu
	task automatic pwr(input csf_pkg::csf_pwr_event_type e,
		input logic [1:0] exp);
		csf_exec_model_i.issue(5'h00, 0, 8'h00, 0, csf_pkg::CSF_FLAGS_NONE,
			0, 0, e, 0);
		check(11'({timeout_flag, powerdown_flag}), 11'(exp));
	endtask : pwr
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_write;
		wr(5'h03, 8'hff);
		check(11'(file_rdata), 11'h0ff);
		for (int p = 0; p < 4; p++) begin
			wr(5'h03, {1'b0, 2'(p), 5'h00});
			check(11'(page_select), 11'(p));
		end
		wr(5'h04, 8'h00);
		check(11'(file_rdata), 11'h078);
	endtask : t_write
	task automatic t_clear;
		wr(5'h03, 8'he3);
		csf_exec_model_i.issue(5'h03, 0, 0, 1, csf_pkg::CSF_FLAGS_NONE, 0, 0,
			csf_pkg::CSF_PWR_NONE, 0);
		check(11'(file_rdata), 11'h01f);
	endtask : t_clear
	task automatic t_misc;
		alu(csf_pkg::CSF_FLAGS_ADD, 8'h0f, 8'h01, 3'h2);
		check(11'(alu_result), 11'h010);
		alu(csf_pkg::CSF_FLAGS_ADD, 8'hff, 8'h01, 3'h7);
		alu(csf_pkg::CSF_FLAGS_SUB, 8'h01, 8'h10, 3'h1);
		alu(csf_pkg::CSF_FLAGS_RRF, 8'h00, 8'h01, 3'h1);
		alu(csf_pkg::CSF_FLAGS_RLF, 8'h00, 8'h80, 3'h1);
		alu(csf_pkg::CSF_FLAGS_Z, 8'h00, 8'h00, 3'h4);
		pwr(csf_pkg::CSF_PWR_SLEEP, 2'h2);
		wr(5'h03, 8'hff);
		check(11'(file_rdata[4:3]), 11'h002);
		pwr(csf_pkg::CSF_PWR_WDT_TIMEOUT, 2'h0);
		pwr(csf_pkg::CSF_PWR_WDT_CLEAR, 2'h3);
		wr(5'h03, 8'h40);
		csf_exec_model_i.issue(0, 0, 8'h5a, 0, csf_pkg::CSF_FLAGS_NONE, 0, 0,
			csf_pkg::CSF_PWR_NONE, 1);
		check(call_pc, 11'h45a);
		pwr(csf_pkg::CSF_PWR_SLEEP, 2'h2);
		csf_exec_model_i.master_clear(0);
		check(11'({page_select, timeout_flag, powerdown_flag}), 11'h3);
		csf_exec_model_i.master_clear(1);
	endtask : t_misc
	initial begin
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		check(11'(file_rdata), 11'h018);
		t_write;
		t_clear;
		t_misc;
		test_done;
	end
	initial begin
		#20000;
		mismatches++;
		test_done;
	end
endmodule : csf_status_reg_tb_top

`default_nettype wire
